//--- verilog/sar_pkg.sv
// Shared constants of the converter readout link: widths, timing, counts.
// Assumes both ends run a 20 MHz ref_clk; conversion bounds are plain defaults.
package sar_pkg;
  localparam int RESULT_W = 16;
  localparam int REF_PERIOD_NS = 50;
  // Conversion time bounds, in ns
  localparam int T_CONV_MIN_NS = 500;
  localparam int T_CONV_MAX_NS = 1000;
  // Least time rounds up, longest time rounds down
  localparam int CONV_MIN_CYC = (T_CONV_MIN_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
  localparam int CONV_MAX_CYC = T_CONV_MAX_NS / REF_PERIOD_NS;
  localparam int CNT_W = 8;
  localparam int BIT_CNT_W = 5;
  // Falling edges that end a read without and with the busy bit
  localparam logic [BIT_CNT_W-1:0] EDGES_PLAIN = 5'h10;
  localparam logic [BIT_CNT_W-1:0] EDGES_BUSY = 5'h11;
  localparam logic [7:0] LFSR_SEED = 8'h5a;
  localparam logic [7:0] LFSR_TAPS = 8'hb8;
  // Host timing, in ref_clk cycles
  localparam int START_HOLD_CYC = 4;
  localparam int SETTLE_CYC = 8;
  localparam int SCLK_HALF_CYC = 4;
  localparam int BUSY_WAIT_CYC = 200;
endpackage : sar_pkg

//--- verilog/sar_link_if.sv
// Three-wire link between converter end and host end.
// Assumes the serial output line carries a pull-up when nobody drives it.
`timescale 1ns/1ns
interface sar_link_if;
  logic conversionStartInput;
  logic din;
  logic sclk;
  logic doutData;
  logic doutOe;
  logic doutPin;

  // Pull-up resolves the released line to high
  assign doutPin = doutOe ? doutData : 1'b1;

  modport device (
    input conversionStartInput,
    input din,
    input sclk,
    output doutData,
    output doutOe
  );
  modport host (
    output conversionStartInput,
    output din,
    output sclk,
    input doutPin
  );
endinterface : sar_link_if

//--- verilog/sar_adc_end.sv
// Converter end: conversion control on ref_clk, serial readout on the link clock.
// Assumes the host keeps the link timing, and stops sclk while converting.
//
// Overview of operation
// (R1) Data input high at start selects chip-select mode
// (R2) Data input low at start selects daisy-chain mode; here that mode only keeps the output released
// (R3) Optional busy bit precedes result bits
// (R4) Three-wire: data input high, start doubles as select
// (R5) Start rise: release output, sample, start converting
// (R6) Internal clock times conversion, start level ignored
// (R7) Conversion length varies between min and max
// (R8) Serial clock only reads; host reads after conversion
// (R9) Conversion end enters acquisition, converter powered down
// (R10) Host returns start high before min, holds past max
// (R11) Start high at conversion end: no busy bit
// (R12) Start falling after max drives MSB out
// (R13) Lower bits follow on successive clock falling edges
// (R14) Bits held stable across both clock edges
// (R15) Released after 16th falling edge or start high
// (R16) Busy mode: host holds start low min to max
// (R17) Start low at end: drive low busy bit
// (R18) Result follows busy bit, MSB first, per falling edge
// (R19) Busy mode: released after 17th falling edge
// (R20) Result coded in two's complement
// (R21) Output released and clock ignored unless reading
`timescale 1ns/1ns
module sar_adc_end
  import sar_pkg::*;
#(
  parameter int CONV_MIN = CONV_MIN_CYC,
  parameter int CONV_MAX = CONV_MAX_CYC
) (
  input wire logic ref_clk,
  input wire logic reset,
  sar_link_if.device link,
  input wire logic [RESULT_W-1:0] sampleCode,
  output logic [RESULT_W-1:0] result,
  output logic resultValid,
  output logic converting,
  output logic powerDown,
  output logic csMode,
  output logic busyMode
);

  if (CONV_MIN < 1 || CONV_MIN > CONV_MAX || CONV_MAX >= (1 << CNT_W)) begin : gBadBounds
    $error("sar_adc_end: conversion bounds out of range");
  end

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_CONV = 3'b010,
    ST_ACQ = 3'b100
  } sar_state_t;

  localparam logic [CNT_W-1:0] MIN_CNT = CNT_W'(CONV_MIN);
  localparam logic [CNT_W-1:0] SPAN = CNT_W'(CONV_MAX - CONV_MIN);

  // Extra cycles beyond the minimum, never past the maximum
  function automatic logic [CNT_W-1:0] pickExtra(input logic [7:0] rnd);
    logic [CNT_W-1:0] v;
    v = CNT_W'(rnd);
    pickExtra = (v > SPAN) ? (v & SPAN) : v;
  endfunction : pickExtra

  // Bit on the line for a given count of falling edges
  function automatic logic pickBit(input logic [RESULT_W-1:0] word,
                                   input logic [BIT_CNT_W-1:0] cnt,
                                   input logic withBusy);
    logic [BIT_CNT_W-1:0] idx;
    idx = withBusy ? cnt - 5'h01 : cnt;
    if (withBusy && cnt == 5'h00) begin
      pickBit = 1'b0;
    end else if (idx < EDGES_PLAIN) begin
      pickBit = word[4'(RESULT_W - 1) - idx[3:0]];
    end else begin
      pickBit = 1'b0;
    end
  endfunction : pickBit

  sar_state_t state;
  logic startMeta;
  logic startSync;
  logic startPrev;
  logic dinMeta;
  logic dinS;
  logic startRise;
  logic [CNT_W-1:0] convCnt;
  logic [CNT_W-1:0] convLen;
  logic [7:0] lfsr;
  logic [RESULT_W-1:0] heldSample;
  logic readEnable;
  logic [BIT_CNT_W-1:0] edgeCnt;
  logic [BIT_CNT_W-1:0] edgeLimit;
  logic linkClear;
  logic linkDone;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      startMeta <= 1'b0;
      startSync <= 1'b0;
      startPrev <= 1'b0;
      dinMeta <= 1'b0;
      dinS <= 1'b0;
    end else begin
      startMeta <= link.conversionStartInput;
      startSync <= startMeta;
      startPrev <= startSync;
      dinMeta <= link.din;
      dinS <= dinMeta;
    end
  end

  assign startRise = startSync && !startPrev;

  ////////////////////////////////////////////////////////////////////////////
  // Conversion sequencing
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: begin
          if (startRise) begin
            state <= ST_CONV; // (R5)
          end
        end
        ST_CONV: begin
          // Start level is not looked at until the count runs out
          if (convCnt == convLen) begin
            state <= ST_ACQ; // (R6) (R9)
          end
        end
        ST_ACQ: begin
          // A new start abandons any read still under way
          if (startRise) begin
            state <= ST_CONV; // (R5)
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      lfsr <= LFSR_SEED;
    end else begin
      lfsr <= {lfsr[6:0], ^(lfsr & LFSR_TAPS)};
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      convCnt <= '0;
      convLen <= MIN_CNT;
    end else if (startRise && state != ST_CONV) begin
      convCnt <= 8'h01;
      convLen <= MIN_CNT + pickExtra(lfsr); // (R7)
    end else if (state == ST_CONV) begin
      convCnt <= convCnt + 8'h01; // (R6)
    end
  end

  // Interface mode and sample are caught at the start edge
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      csMode <= 1'b0;
      heldSample <= '0;
    end else if (startRise && state != ST_CONV) begin
      csMode <= dinS; // (R1) (R2) (R4)
      heldSample <= sampleCode; // (R5)
    end
  end

  // Busy bit only when start is low as the conversion ends
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      busyMode <= 1'b0;
      result <= '0;
      resultValid <= 1'b0;
    end else begin
      resultValid <= 1'b0;
      if (state == ST_CONV && convCnt == convLen) begin
        busyMode <= !startSync; // (R3) (R11) (R17)
        result <= heldSample; // (R20)
        resultValid <= 1'b1;
      end
    end
  end

  assign converting = (state == ST_CONV);
  assign powerDown = (state != ST_CONV); // (R9)
  // Daisy-chain shifting is not built; that mode keeps the line released
  assign readEnable = (state == ST_ACQ) && csMode; // (R8) (R21)

  ////////////////////////////////////////////////////////////////////////////
  // Link clock domain: falling-edge counter
  // Start high ends the frame; sclk may stop, so the clear cannot wait for it.
  // readEnable, busyMode and result only change while sclk is idle.
  assign linkClear = reset || link.conversionStartInput;
  assign edgeLimit = busyMode ? EDGES_BUSY : EDGES_PLAIN;

  always_ff @(negedge link.sclk or posedge linkClear) begin
    if (linkClear) begin
      edgeCnt <= '0;
    end else if (readEnable && edgeCnt != edgeLimit) begin
      edgeCnt <= edgeCnt + 5'h01; // (R13) (R18) (R21)
    end
  end

  always_ff @(negedge link.sclk or posedge linkClear) begin
    if (linkClear) begin
      linkDone <= 1'b0;
    end else if (readEnable && edgeCnt + 5'h01 == edgeLimit) begin
      linkDone <= 1'b1; // (R15) (R19)
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial output
  // Bit changes only on falling edges, so it stands across the rising one
  assign link.doutData = pickBit(result, edgeCnt, busyMode); // (R12) (R14) (R17) (R18)
  // Released while start is high, before acquisition, or after the last edge
  // Raw start gates too: the frame clear would otherwise re-enable the line
  // for the two cycles before the synchronised start catches up
  assign link.doutOe = readEnable && !startSync && !linkDone && !linkClear; // (R5) (R15) (R21)

endmodule : sar_adc_end

//--- verilog/sar_host_end.sv
// Host end: starts conversions, drives the link clock, collects the result.
// Assumes the converter end is wired through sar_link_if in three-wire mode.
`timescale 1ns/1ns
module sar_host_end
  import sar_pkg::*;
#(
  parameter int CONV_MAX = CONV_MAX_CYC,
  parameter int START_HOLD = START_HOLD_CYC,
  parameter int HALF = SCLK_HALF_CYC,
  parameter int BUSY_WAIT = BUSY_WAIT_CYC
) (
  input wire logic ref_clk,
  input wire logic reset,
  sar_link_if.host link,
  input wire logic startReq,
  input wire logic useBusy,
  output logic ready,
  output logic [RESULT_W-1:0] readData,
  output logic readValid,
  output logic timeoutErr
);

  if (START_HOLD < 1 || HALF < 4 || CONV_MAX + SETTLE_CYC >= (1 << CNT_W)
      || BUSY_WAIT >= (1 << CNT_W)) begin : gBadTiming
    $error("sar_host_end: timing parameters out of range");
  end

  typedef enum logic [4:0] {
    H_IDLE = 5'b00001,
    H_START = 5'b00010,
    H_WAIT = 5'b00100,
    H_LOW = 5'b01000,
    H_HIGH = 5'b10000
  } sar_host_state_t;

  localparam logic [CNT_W-1:0] HOLD_END = CNT_W'(START_HOLD - 1);
  // Past the longest conversion plus the converter's pin synchroniser
  localparam logic [CNT_W-1:0] PLAIN_END = CNT_W'(CONV_MAX + SETTLE_CYC);
  localparam logic [CNT_W-1:0] SETTLE_END = CNT_W'(SETTLE_CYC);
  localparam logic [CNT_W-1:0] HALF_END = CNT_W'(HALF - 1);
  localparam logic [CNT_W-1:0] WAIT_END = CNT_W'(BUSY_WAIT);

  sar_host_state_t state;
  logic [CNT_W-1:0] timer;
  logic [BIT_CNT_W-1:0] edgeIdx;
  logic withBusy;
  logic doutMeta;
  logic doutS;
  logic [RESULT_W-1:0] shiftIn;

  assign link.din = 1'b1; // (R4)
  assign ready = (state == H_IDLE);

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      doutMeta <= 1'b1;
      doutS <= 1'b1;
    end else begin
      doutMeta <= link.doutPin;
      doutS <= doutMeta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state <= H_IDLE;
      timer <= '0;
      edgeIdx <= '0;
      withBusy <= 1'b0;
      link.conversionStartInput <= 1'b0;
      link.sclk <= 1'b0;
      shiftIn <= '0;
      readData <= '0;
      readValid <= 1'b0;
      timeoutErr <= 1'b0;
    end else begin
      readValid <= 1'b0;
      timeoutErr <= 1'b0;
      timer <= timer + 8'h01;
      case (state)
        H_IDLE: begin
          if (startReq) begin
            link.conversionStartInput <= 1'b1;
            withBusy <= useBusy;
            timer <= '0;
            state <= H_START;
          end
        end
        H_START: begin
          if (withBusy && timer == HOLD_END) begin
            link.conversionStartInput <= 1'b0; // (R16)
            timer <= '0;
            state <= H_WAIT;
          end else if (!withBusy && timer == PLAIN_END) begin
            link.conversionStartInput <= 1'b0; // (R10) (R12)
            timer <= '0;
            state <= H_WAIT;
          end
        end
        H_WAIT: begin
          // Busy bit pulls the line low; plain mode waits for the MSB
          if ((withBusy && !doutS) || (!withBusy && timer == SETTLE_END)) begin
            timer <= '0;
            edgeIdx <= '0;
            state <= H_LOW; // (R8)
          end else if (withBusy && timer == WAIT_END) begin
            timeoutErr <= 1'b1;
            state <= H_IDLE;
          end
        end
        H_LOW: begin
          if (timer == HALF_END) begin
            // Sampled before the rise; the bit has stood a full half period
            if (!withBusy || edgeIdx != 5'h00) begin
              shiftIn <= {shiftIn[RESULT_W-2:0], doutS}; // (R14)
            end
            link.sclk <= 1'b1;
            timer <= '0;
            state <= H_HIGH;
          end
        end
        H_HIGH: begin
          if (timer == HALF_END) begin
            link.sclk <= 1'b0;
            timer <= '0;
            edgeIdx <= edgeIdx + 5'h01;
            if (edgeIdx + 5'h01 == (withBusy ? EDGES_BUSY : EDGES_PLAIN)) begin
              readData <= shiftIn;
              readValid <= 1'b1;
              state <= H_IDLE;
            end else begin
              state <= H_LOW;
            end
          end
        end
        default: begin
          state <= H_IDLE;
        end
      endcase
    end
  end

endmodule : sar_host_end

//--- tb/sar_link_monitor.sv
// Concurrent checks on the three-wire link and the converter state.
// Assumes one ref_clk domain with an active-high asynchronous reset.
`timescale 1ns/1ns
module sar_link_monitor #(
  parameter int CONV_MIN = 10,
  parameter int CONV_MAX = 20
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic conversionStartInput,
  input wire logic din,
  input wire logic sclk,
  input wire logic doutData,
  input wire logic doutOe,
  input wire logic doutPin,
  input wire logic converting,
  input wire logic resultValid,
  input wire logic busyMode
);
  int convCnt;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);

  ////////////////////////////////////////////////////////////////////////////
  // Cycles spent converting; one cycle of slack for the start sync
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      convCnt <= 0;
    end else if (converting) begin
      convCnt <= convCnt + 1;
    end else begin
      convCnt <= 0;
    end
  end

  sequence convEnd;
    $fell(converting);
  endsequence

  sequence startSeen;
    $rose(conversionStartInput);
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  conv_release_a: assert property (converting |-> !doutOe)
    else $error("line driven during conversion");
  start_conv_a: assert property (startSeen |-> ##[1:4] converting)
    else $error("start not followed by conversion");
  start_release_a: assert property (startSeen |-> !doutOe [*3])
    else $error("line driven after start rise");
  conv_length_a: assert property (convEnd |->
    (convCnt >= CONV_MIN - 1) && (convCnt <= CONV_MAX + 1))
    else $error("conversion length out of bounds");
  acq_power_a: assert property (resultValid |-> !converting)
    else $error("result ready while converting");
  bit_hold_a: assert property (doutOe && $past(doutOe) && sclk |-> $stable(doutData))
    else $error("output bit changed while clock high");
  busy_low_a: assert property ($rose(doutOe) && busyMode |-> !doutPin)
    else $error("busy bit not low");
  no_busy_a: assert property (convEnd and conversionStartInput |-> !doutOe [*3])
    else $error("busy bit with start high");
  select_off_a: assert property (conversionStartInput [*4] |-> !doutOe)
    else $error("line driven while deselected");
  din_high_a: assert property (din)
    else $error("data input not held high");
endmodule : sar_link_monitor

//--- tb/sar_adc_serial_readout_3wire_tb.sv
// Bench joining converter end and host end over the three-wire link.
// Assumes the host end runs the read frames; compares read codes.
`timescale 1ns/1ns
module sar_adc_serial_readout_3wire_tb;
  import sar_pkg::*;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic [RESULT_W-1:0] sampleCode = '0;
  logic startReq = 1'b0;
  logic useBusy = 1'b0;
  logic [RESULT_W-1:0] result;
  logic [RESULT_W-1:0] readData;
  logic resultValid, converting, powerDown, csMode, busyMode;
  logic ready, readValid, timeoutErr;
  int fails = 0;
  int n_tests = 0;

  sar_link_if link();
  sar_adc_end sar_adc_end_inst (.ref_clk(ref_clk), .reset(reset), .link(link),
    .sampleCode(sampleCode), .result(result), .resultValid(resultValid),
    .converting(converting), .powerDown(powerDown), .csMode(csMode), .busyMode(busyMode));
  sar_host_end sar_host_end_inst (.ref_clk(ref_clk), .reset(reset), .link(link),
    .startReq(startReq), .useBusy(useBusy), .ready(ready), .readData(readData),
    .readValid(readValid), .timeoutErr(timeoutErr));
  sar_link_monitor #(.CONV_MIN(CONV_MIN_CYC), .CONV_MAX(CONV_MAX_CYC)) sar_link_monitor_inst (
    .ref_clk(ref_clk), .reset(reset), .conversionStartInput(link.conversionStartInput),
    .din(link.din),
    .sclk(link.sclk), .doutData(link.doutData), .doutOe(link.doutOe),
    .doutPin(link.doutPin), .converting(converting), .resultValid(resultValid),
    .busyMode(busyMode));

  always #25 ref_clk = ~ref_clk;

  ////////////////////////////////////////////////////////////////////////////
  // Code is passed through unchanged, so the signed input is the answer
  function automatic logic [RESULT_W-1:0] expCode(input logic [RESULT_W-1:0] code);
    return code;
  endfunction : expCode

  task automatic check(input logic [RESULT_W-1:0] got, input logic [RESULT_W-1:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // One start and read; sampleCode held to the end, as the device samples at start
  task automatic convert(input logic [RESULT_W-1:0] code, input logic busy);
    int w;
    w = 0;
    while (ready !== 1'b1 && w < 100) begin
      @(posedge ref_clk);
      #2;
      w++;
    end
    sampleCode = code;
    useBusy = busy;
    startReq = 1'b1;
    @(posedge ref_clk);
    #2;
    startReq = 1'b0;
    w = 0;
    while (readValid !== 1'b1 && w < 1000) begin
      @(posedge ref_clk);
      #2;
      w++;
    end
    check({15'h0, readValid}, 16'h0001);
    check(readData, expCode(code));
    check({14'h0, busyMode, csMode}, {14'h0, busy, 1'b1});
    check(result, expCode(code));
    check({14'h0, powerDown, converting}, 16'h0002);
  endtask : convert

  // A busy frame must never run out waiting for the busy bit
  always @(posedge ref_clk) begin
    if (!reset) begin
      check({15'h0, timeoutErr}, 16'h0000);
    end
  end

  task automatic results();
    $display("fails=%0d n_tests=%0d", fails, n_tests);
    if (fails == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : results

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(65291));
    repeat (2) @(posedge ref_clk);
    #2;
    reset = 1'b0;
    // Extremes of the two's complement range, zero and minus one, both framings
    convert(16'h8000, 1'b0);
    convert(16'h7fff, 1'b1);
    convert(16'h0000, 1'b1);
    convert(16'hffff, 1'b0);
    for (int i = 0; i < 16; i++) begin
      convert(RESULT_W'($urandom), 1'($urandom));
    end
    results();
  end

  // Twenty frames need about 3400 cycles; allow well over that
  initial begin
    #1000000;
    fails++;
    results();
  end
endmodule : sar_adc_serial_readout_3wire_tb
